// [cies_exec.sv]
// execute stage for clear, skip, jump, or-literal and increment instructions
// assumes the file register is read combinationally at file_addr and
// written at the end of the cycle when file_we is high
`timescale 1ns/10ps
module cies_exec (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // instruction from fetch
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [6:0] page_latch,
  // file register port
  output logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [7:0] file_wdata,
  // architectural state
  output logic [7:0] accum,
  output logic result_null_flag,
  output logic [14:0] pc,
  // pipeline control
  output logic flush_next,
  output logic exec_busy
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {CIES_RUN, CIES_SQUASH} cies_state_t;
  cies_state_t state_q, state_d;
  logic [7:0] accum_q, accum_d;
  logic zf_q, zf_d;
  logic [14:0] pc_q, pc_d;
  cies_pkg::cies_op_t op;
  logic [7:0] dec_res, inc_res, or_res, alu_res;
  logic dest_file, run, res_zero, is_skip;

  cies_decode u_dec (
    .instr(instr),
    .op(op)
  );

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  // a squashed slot runs as a no-op whatever fetch presents
  assign run = instr_valid && (state_q == CIES_RUN);
  assign file_addr = instr[cies_pkg::FA_W-1:0];
  assign dest_file = instr[cies_pkg::DEST_BIT];
  assign dec_res = file_rdata - cies_pkg::BYTE_ONE;
  assign inc_res = file_rdata + cies_pkg::BYTE_ONE;
  assign or_res = accum_q | instr[7:0];
  assign alu_res = (op == cies_pkg::CIES_OP_DEC) ? dec_res :
                   (op == cies_pkg::CIES_OP_OR) ? or_res : inc_res;
  assign res_zero = (alu_res == cies_pkg::BYTE_ZERO);
  assign is_skip = (op == cies_pkg::CIES_OP_DEC) || (op == cies_pkg::CIES_OP_INC_SKIP);
  // file write for the three read-modify-write ops with d=1
  assign file_we = run && dest_file && (is_skip || op == cies_pkg::CIES_OP_INC);
  assign file_wdata = alu_res;

  // next state of accumulator, flag and pc
  always_comb begin
    accum_d = accum_q;
    zf_d = zf_q;
    pc_d = pc_q;
    state_d = CIES_RUN;
    if (run) begin
      pc_d = pc_q + 15'h0001;
      case (op)
        cies_pkg::CIES_OP_CLR: begin
          accum_d = cies_pkg::BYTE_ZERO;
          zf_d = 1'b1;
        end
        cies_pkg::CIES_OP_DEC, cies_pkg::CIES_OP_INC_SKIP: begin
          if (!dest_file) begin
            accum_d = alu_res;
          end
          if (res_zero) begin
            state_d = CIES_SQUASH;
          end
        end
        cies_pkg::CIES_OP_INC: begin
          if (!dest_file) begin
            accum_d = alu_res;
          end
          zf_d = res_zero;
        end
        cies_pkg::CIES_OP_OR: begin
          accum_d = alu_res;
          zf_d = res_zero;
        end
        cies_pkg::CIES_OP_JUMP: begin
          // upper pc from page latch, flags untouched
          pc_d = {page_latch[cies_pkg::PAGE_HI:cies_pkg::PAGE_LO],
                  instr[cies_pkg::JMP_W-1:0]};
          state_d = CIES_SQUASH;
        end
        default: begin
        end
      endcase
    end else if (instr_valid) begin
      pc_d = pc_q + 15'h0001; // squashed slot still advances for skips
    end
  end

  // squashed slot after a jump must not advance the new pc
  logic jumped_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      jumped_q <= 1'b0;
    end else if (instr_valid) begin
      jumped_q <= run && (op == cies_pkg::CIES_OP_JUMP);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= CIES_RUN;
      accum_q <= cies_pkg::BYTE_ZERO;
      zf_q <= 1'b0;
      pc_q <= cies_pkg::PC_RESET;
    end else begin
      state_q <= instr_valid ? state_d : state_q;
      accum_q <= accum_d;
      zf_q <= zf_d;
      pc_q <= (instr_valid && !run && jumped_q) ? pc_q : pc_d;
    end
  end

  assign accum = accum_q;
  assign result_null_flag = zf_q;
  assign pc = pc_q;
  // tells fetch that the word now in flight is thrown away
  assign flush_next = (state_q == CIES_SQUASH);
  assign exec_busy = (state_q == CIES_SQUASH);
endmodule

// [cies_pkg.sv]
// package for the six-instruction execute subset of the 8-bit core
// assumes a 14-bit instruction word and a 15-bit program counter
// How it works
// - clear_accumulator writes 00h to the accumulator and always sets the null flag.
// - decrement_skip_on_null writes f-1 to the accumulator (d=0) or to f (d=1), flags untouched.
// - a zero decrement result squashes the next instruction into a no-op, giving 2 cycles.
// - increment_skip_on_null writes f+1 by d, flags untouched, and skips on a zero result.
// - absolute_jump loads its 11-bit operand (0 to 2047) into pc bits 10:0.
// - absolute_jump fills pc bits 14:11 from page_latch bits 6:3.
// - absolute_jump takes two cycles and leaves all flags alone.
// - or_literal_into_accumulator ORs an 8-bit literal into the accumulator and updates the null flag.
// - increment_file_register writes f+1 by d and updates the null flag.
package cies_pkg;
  // ----------------------------------------
  // instruction word layout
  // ----------------------------------------
  localparam int IW_W = 14;
  localparam int PC_W = 15;
  localparam int FA_W = 7;
  localparam int DEST_BIT = 7;
  localparam int JMP_W = 11;
  localparam int PAGE_HI = 6;
  localparam int PAGE_LO = 3;
  // ----------------------------------------
  // opcodes and masks
  // ----------------------------------------
  localparam logic [13:0] OP_CLRACC = 14'h0100;
  localparam logic [13:0] MK_CLRACC = 14'h3F80;
  localparam logic [13:0] OP_DECSKIP = 14'h0B00;
  localparam logic [13:0] OP_INCSKIP = 14'h0F00;
  localparam logic [13:0] OP_INCREMENT_FILE_REGISTER = 14'h0A00;
  localparam logic [13:0] MK_FD = 14'h3F00;
  localparam logic [13:0] OP_JUMP = 14'h2800;
  localparam logic [13:0] MK_JUMP = 14'h3800;
  localparam logic [13:0] OP_ORLIT = 14'h3800;
  localparam logic [13:0] MK_ORLIT = 14'h3F00;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [14:0] PC_RESET = 15'h0000;
  typedef enum logic [2:0] {
    CIES_OP_NONE, CIES_OP_CLR, CIES_OP_DEC, CIES_OP_INC_SKIP,
    CIES_OP_JUMP, CIES_OP_OR, CIES_OP_INC
  } cies_op_t;
endpackage

// [cies_decode.sv]
// instruction decoder for the execute subset
// assumes a registered instruction word from the fetch stage
`timescale 1ns/10ps
module cies_decode (
  // instruction
  input wire logic [13:0] instr,
  // decoded class
  output cies_pkg::cies_op_t op
);
  // ----------------------------------------
  // opcode match
  // ----------------------------------------
  function automatic logic hit(input logic [13:0] w, input logic [13:0] m,
                               input logic [13:0] v);
    hit = ((w & m) == v);
  endfunction

  // priority chain; opcode classes never overlap
  assign op = hit(instr, cies_pkg::MK_CLRACC, cies_pkg::OP_CLRACC) ? cies_pkg::CIES_OP_CLR :
              hit(instr, cies_pkg::MK_FD, cies_pkg::OP_DECSKIP) ? cies_pkg::CIES_OP_DEC :
              hit(instr, cies_pkg::MK_FD, cies_pkg::OP_INCSKIP) ? cies_pkg::CIES_OP_INC_SKIP :
              hit(instr, cies_pkg::MK_FD, cies_pkg::OP_INCREMENT_FILE_REGISTER) ? cies_pkg::CIES_OP_INC :
              hit(instr, cies_pkg::MK_JUMP, cies_pkg::OP_JUMP) ? cies_pkg::CIES_OP_JUMP :
              hit(instr, cies_pkg::MK_ORLIT, cies_pkg::OP_ORLIT) ? cies_pkg::CIES_OP_OR :
              cies_pkg::CIES_OP_NONE;
endmodule

// [cies_exec_props.sv]
// checker for the execute subset, watching the ports of cies_exec
// assumes the opcode constants and masks of cies_pkg
`timescale 1ns/10ps
module cies_exec_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // instruction side
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [6:0] page_latch,
  // file register port
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  // state and control
  input wire logic [7:0] accum,
  input wire logic result_null_flag,
  input wire logic [14:0] pc,
  input wire logic flush_next,
  input wire logic exec_busy
);
  // ----------------------------------------
  // decode of taken words
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire tk = instr_valid & ~flush_next;
  wire [13:0] fd = instr & cies_pkg::MK_FD;
  wire w_clr = tk & ((instr & cies_pkg::MK_CLRACC) == cies_pkg::OP_CLRACC);
  wire w_dec = tk & (fd == cies_pkg::OP_DECSKIP);
  wire w_ins = tk & (fd == cies_pkg::OP_INCSKIP);
  wire w_inc = tk & (fd == cies_pkg::OP_INCREMENT_FILE_REGISTER);
  wire w_jmp = tk & ((instr & cies_pkg::MK_JUMP) == cies_pkg::OP_JUMP);
  wire w_or = tk & ((instr & cies_pkg::MK_ORLIT) == cies_pkg::OP_ORLIT);
  logic [14:0] jt_q;
  logic [7:0] rd_q, or_q;
  // operands kept one cycle so results can be judged after the edge
  always_ff @(posedge clk_sys) begin
    jt_q <= {page_latch[6:3], instr[10:0]};
    rd_q <= file_rdata;
    or_q <= accum | instr[7:0];
  end
  // the squash slot only ends on a valid word, so a bubble may stretch it
  sequence s_slot;
    flush_next && $stable(result_null_flag);
  endsequence
  sequence s_squash_taken;
    w_jmp ##1 instr_valid;
  endsequence
  a_clear_sets_null: assert property (w_clr |=> accum == 8'h00 && result_null_flag)
    else $error("clear left accumulator or flag wrong");
  a_dec_write: assert property (w_dec |-> file_wdata == file_rdata - 8'h01 && file_we == instr[7])
    else $error("decrement result or destination wrong");
  a_dec_skip: assert property (w_dec |=> flush_next == (rd_q == 8'h01) && $stable(result_null_flag))
    else $error("decrement skip wrong");
  a_incs_skip: assert property (w_ins |-> file_wdata == file_rdata + 8'h01 ##1 flush_next == (rd_q == 8'hFF))
    else $error("increment skip wrong");
  a_jump_target: assert property (w_jmp |=> pc == jt_q)
    else $error("jump target wrong");
  a_jump_slot: assert property (w_jmp |=> s_slot)
    else $error("jump did not take two cycles");
  a_jump_hold: assert property (s_squash_taken |=> !flush_next && $stable(pc))
    else $error("jump slot moved the pc or did not end");
  a_or_literal: assert property (w_or |=> accum == or_q && result_null_flag == (or_q == 8'h00))
    else $error("or literal wrong");
  a_inc_null: assert property (w_inc |-> file_wdata == file_rdata + 8'h01 ##1 result_null_flag == (rd_q == 8'hFF))
    else $error("increment flag wrong");
  a_file_addr: assert property (file_addr == instr[6:0])
    else $error("file address wrong");
endmodule
bind cies_exec cies_exec_props u_props (.*);

// [cpu_instr_exec_subset_test.sv]
// self-checking bench for cies_exec with random instruction streams
// drives the fetch side with random bubbles after reset, instr_valid low for about one word in eight
`timescale 1ns/10ps
module cpu_instr_exec_subset_test;
  // ----------------------------------------
  // stimulus, model and scoreboard
  // ----------------------------------------
  logic clk_sys = 0, arst_n = 0, instr_valid = 0, file_we, result_null_flag, flush_next, exec_busy;
  logic [13:0] instr = 0;
  logic [6:0] page_latch = 0, file_addr;
  logic [7:0] file_rdata = 0, file_wdata, accum, m_acc = 0;
  logic [14:0] pc, m_pc = 0;
  logic m_z = 0, m_fl = 0, m_jh = 0;
  logic [33:0] q[$], e;
  logic [13:0] ops[7] = '{cies_pkg::OP_CLRACC, cies_pkg::OP_DECSKIP, cies_pkg::OP_INCSKIP,
    cies_pkg::OP_INCREMENT_FILE_REGISTER, cies_pkg::OP_JUMP, cies_pkg::OP_ORLIT, cies_pkg::NOP_WORD};
  logic [13:0] mks[7] = '{cies_pkg::MK_CLRACC, cies_pkg::MK_FD, cies_pkg::MK_FD, cies_pkg::MK_FD,
    cies_pkg::MK_JUMP, cies_pkg::MK_ORLIT, 14'h3FFF};
  int error_cnt = 0, checks = 0, seed = 32'hb104_ade8, k, rn;
  cies_exec DUT (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // drive one word and note what the core must do with it
  task automatic step(input logic [13:0] w, input logic [7:0] rd, input logic v);
    logic [7:0] res;
    logic we;
    @(posedge clk_sys);
    #1;
    {instr, file_rdata, instr_valid} = {w, rd, v};
    page_latch = 7'($random(seed));
    we = 0;
    res = rd + ((w & cies_pkg::MK_FD) == cies_pkg::OP_DECSKIP ? 8'hFF : 8'h01);
    // a bubble must leave every piece of state held, squash slot included
    if (!v) return;
    if (m_fl) begin
      m_pc = m_jh ? m_pc : m_pc + 1;
      m_fl = 0;
    end else begin
      m_pc = m_pc + 1;
      m_jh = 0;
      case (k)
        0: {m_acc, m_z} = {8'h00, 1'b1};
        4: {m_pc, m_fl, m_jh} = {page_latch[6:3], w[10:0], 2'b11};
        5: m_acc = m_acc | w[7:0];
        1, 2, 3: begin
          we = w[7];
          m_acc = w[7] ? m_acc : res;
          if (k == 3) m_z = res == 8'h00;
          else m_fl = res == 8'h00;
        end
        default: ;
      endcase
      if (k == 5) m_z = m_acc == 8'h00;
    end
    q.push_back({we, we ? res : 8'h00, m_acc, m_z, m_pc, m_fl});
  endtask
  // oldest note against what the core shows for the word just taken
  always @(posedge clk_sys) begin
    if (instr_valid && q.size() > 0) begin
      e = q.pop_front();
      chk({file_we, file_we ? file_wdata : 8'h00, file_addr}, {e[33:25], instr[6:0]});
      #3;
      chk({accum, result_null_flag, pc, flush_next, exec_busy}, {e[24:0], e[0]});
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    chk({accum, result_null_flag, pc, flush_next, exec_busy}, 0);
    #1 arst_n = 1;
    for (int i = 0; i < 600; i++) begin
      // mid-run reset: let the last word settle, idle one cycle, then pulse
      if (i == 300) begin
        @(posedge clk_sys);
        #1 instr_valid = 0;
        @(posedge clk_sys);
        #1 arst_n = 0;
        {m_acc, m_z, m_pc, m_fl, m_jh} = '0;
        @(negedge clk_sys);
        chk({accum, result_null_flag, pc, flush_next, exec_busy}, 0);
        @(posedge clk_sys);
        #1 arst_n = 1;
      end
      k = {$random(seed)} % 7;
      rn = $random(seed);
      step(ops[k] | (rn[13:0] & ~mks[k]),
           rn[15:14] == 0 ? 8'h01 : rn[15:14] == 1 ? 8'hFF : rn[23:16],
           rn[26:24] != 3'h0);
    end
    @(posedge clk_sys);
    #5;
    if (q.size() != 0) error_cnt++;
    tally_and_finish();
  end
endmodule
